// File: lfaso_pkg.sv
// Package for the literal, file, add and shift execution block.
// Assumes a single 200 MHz core clock and 14-bit instruction words.
package lfaso_pkg;

    // ------------------------------------------------------------
    // Widths and address space
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int PTR_W = 16;
    localparam int FADDR_W = 7;
    localparam int FDEPTH = 128;
    localparam int IMM6_W = 6;

    // ------------------------------------------------------------
    // Opcode prefixes (upper bits of the 14-bit word)
    // ------------------------------------------------------------
    localparam logic [6:0] OP_PTR_ADD = 7'h62;   // 11 0001 0
    localparam logic [5:0] OP_AND_IMM = 6'h39;   // 11 1001
    localparam logic [5:0] OP_ADD_IMM = 6'h3e;   // 11 1110
    localparam logic [5:0] OP_AND_FILE = 6'h05;  // 00 0101
    localparam logic [5:0] OP_ADD_FILE = 6'h07;  // 00 0111
    localparam logic [5:0] OP_ASR_FILE = 6'h37;  // 11 0111
    localparam logic [5:0] OP_ADDC_FILE = 6'h3d; // 11 1101

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DEST_BIT = 7;
    localparam int PSEL_BIT = 6;

    // File addresses that act as indirect data ports
    localparam logic [6:0] IND_PORT0 = 7'h00;
    localparam logic [6:0] IND_PORT1 = 7'h01;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [15:0] PTR_RST = 16'h0000;

    // ------------------------------------------------------------
    // Sequencer states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_XTRA = 3'b010,
        ST_EXEC = 3'b100
    } lfaso_state_t;

endpackage

// File: lfaso_mem_if.sv
// Interface between the execution core and its file-register memory.
// Assumes both ends run on the same core clock.
interface lfaso_mem_if;
    logic rd_en;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;
    logic wr_en;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;

    modport core (output rd_en, output rd_addr, input rd_data,
                  output wr_en, output wr_addr, output wr_data);
    modport mem (input rd_en, input rd_addr, output rd_data,
                 input wr_en, input wr_addr, input wr_data);
endinterface

// File: lfaso_file_mem.sv
// File-register memory of one data bank, 128 bytes.
// Assumes one read and one write port; read data come out of a register.
module lfaso_file_mem (
    // Clock
    input wire logic clk,
    // Memory port
    lfaso_mem_if.mem port
);

    logic [7:0] mem_ff [lfaso_pkg::FDEPTH];
    logic [7:0] rd_ff;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Memory has no reset; contents are loaded by writes
    always_ff @(posedge clk) begin
        if (port.wr_en) begin
            mem_ff[port.wr_addr] <= port.wr_data;
        end
        if (port.rd_en) begin
            rd_ff <= mem_ff[port.rd_addr];
        end
    end

    assign port.rd_data = rd_ff;

endmodule

// File: lfaso_core.sv
// Execution core for pointer add, AND/ADD with literal or file register,
// add with carry and arithmetic shift right.
// Assumes the decoder presents one instruction at a time, held while
// ready is low; file loads come from an outside port while idle.

// Functional notes
// - Pointer add: sign-extended 6-bit literal added to selected pair, flags kept.
// - Pointer pair wraps modulo 65536, never saturates.
// - AND literal: accumulator AND 8-bit literal into accumulator, zero only.
// - ADD literal: 8-bit literal plus accumulator, updates carry, half carry, zero.
// - AND file: accumulator AND file register, updates zero only.
// - Destination bit 0 writes accumulator, 1 writes the file register back.
// - ADD file: accumulator plus file register, updates carry, half carry, zero.
// - Shift right: file shifted by one, old bit 0 into carry, zero updated.
// - Shift right keeps the original top bit as the result's top bit.
// - Add with carry: accumulator plus file plus carry, to destination, flags.
// - Pointer add decoded from upper bits 11 0001 0, selector, six literal bits.
// - Indirect access with pointer top bit set costs one extra cycle.
module lfaso_core (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Instruction in
    input wire logic instr_valid,
    input wire logic [13:0] instr_word,
    // File register load, taken only while idle and no instruction
    input wire logic ld_valid,
    input wire logic [6:0] ld_addr,
    input wire logic [7:0] ld_data,
    // Handshake
    output logic ready,
    output logic done,
    // Architectural state
    output logic [7:0] acc,
    output logic carry_flag,
    output logic half_carry_flag,
    output logic zero_flag,
    output logic [15:0] indirect_pointer_pair0,
    output logic [15:0] indirect_pointer_pair1,
    // File write monitor
    output logic fw_valid,
    output logic [6:0] fw_addr,
    output logic [7:0] fw_data
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        lfaso_pkg::lfaso_state_t state;
        logic [13:0] instr;
        logic [6:0] eaddr;
        logic [7:0] acc;
        logic c;
        logic hc;
        logic z;
        logic [15:0] ptr0;
        logic [15:0] ptr1;
        logic ready;
        logic done;
        logic fw_valid;
        logic [6:0] fw_addr;
        logic [7:0] fw_data;
    } lfaso_regs_t;

    lfaso_regs_t r_ff;
    lfaso_regs_t nxt_r;
    lfaso_mem_if mif ();

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Returns {carry, half carry, sum}
    function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        return {s[8], h[4], s[7:0]};
    endfunction

    // True for the file-register operations
    function automatic logic is_file_op(input logic [13:0] w);
        return (w[13:8] == lfaso_pkg::OP_AND_FILE) || (w[13:8] == lfaso_pkg::OP_ADD_FILE) ||
               (w[13:8] == lfaso_pkg::OP_ASR_FILE) || (w[13:8] == lfaso_pkg::OP_ADDC_FILE);
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [6:0] faddr;
        logic [7:0] opnd;
        logic [7:0] res;
        logic [9:0] sum;
        logic [15:0] kext;
        logic ind;
        logic ind_hi;
        logic wr_back;
        faddr = instr_word[6:0];
        opnd = mif.rd_data;
        res = 8'h00;
        sum = 10'h000;
        kext = {{10{r_ff.instr[5]}}, r_ff.instr[5:0]};
        ind = 1'b0;
        ind_hi = 1'b0;
        wr_back = 1'b0;
        nxt_r = r_ff;
        nxt_r.done = 1'b0;
        nxt_r.fw_valid = 1'b0;
        mif.rd_en = 1'b0;
        mif.rd_addr = 7'h00;
        mif.wr_en = 1'b0;
        mif.wr_addr = 7'h00;
        mif.wr_data = 8'h00;
        case (r_ff.state)
            lfaso_pkg::ST_IDLE: begin
                if (instr_valid) begin
                    // Indirect ports redirect through the low pointer bits
                    if (faddr == lfaso_pkg::IND_PORT0) begin
                        ind = 1'b1;
                        ind_hi = r_ff.ptr0[15];
                        faddr = r_ff.ptr0[6:0];
                    end else if (faddr == lfaso_pkg::IND_PORT1) begin
                        ind = 1'b1;
                        ind_hi = r_ff.ptr1[15];
                        faddr = r_ff.ptr1[6:0];
                    end
                    mif.rd_en = 1'b1;
                    mif.rd_addr = faddr;
                    nxt_r.instr = instr_word;
                    nxt_r.eaddr = faddr;
                    nxt_r.ready = 1'b0;
                    if (is_file_op(instr_word) && ind && ind_hi) begin
                        nxt_r.state = lfaso_pkg::ST_XTRA;
                    end else begin
                        nxt_r.state = lfaso_pkg::ST_EXEC;
                    end
                end else if (ld_valid) begin
                    // Loads are only taken here so they never race an operand read
                    mif.wr_en = 1'b1;
                    mif.wr_addr = ld_addr;
                    mif.wr_data = ld_data;
                end
            end
            lfaso_pkg::ST_XTRA: begin
                // Stall cycle; read data stays in the memory output register
                nxt_r.state = lfaso_pkg::ST_EXEC;
            end
            lfaso_pkg::ST_EXEC: begin
                nxt_r.state = lfaso_pkg::ST_IDLE;
                nxt_r.ready = 1'b1;
                nxt_r.done = 1'b1;
                if (r_ff.instr[13:7] == lfaso_pkg::OP_PTR_ADD) begin
                    // 16-bit sum drops its carry, so it wraps by itself
                    if (r_ff.instr[lfaso_pkg::PSEL_BIT]) begin
                        nxt_r.ptr1 = r_ff.ptr1 + kext;
                    end else begin
                        nxt_r.ptr0 = r_ff.ptr0 + kext;
                    end
                end else begin
                    case (r_ff.instr[13:8])
                        lfaso_pkg::OP_AND_IMM: begin
                            nxt_r.acc = r_ff.acc & r_ff.instr[7:0];
                            nxt_r.z = (nxt_r.acc == 8'h00);
                        end
                        lfaso_pkg::OP_ADD_IMM: begin
                            sum = add8(r_ff.acc, r_ff.instr[7:0], 1'b0);
                            nxt_r.acc = sum[7:0];
                            nxt_r.c = sum[9];
                            nxt_r.hc = sum[8];
                            nxt_r.z = (sum[7:0] == 8'h00);
                        end
                        lfaso_pkg::OP_AND_FILE: begin
                            res = r_ff.acc & opnd;
                            nxt_r.z = (res == 8'h00);
                            wr_back = 1'b1;
                        end
                        lfaso_pkg::OP_ADD_FILE: begin
                            sum = add8(r_ff.acc, opnd, 1'b0);
                            res = sum[7:0];
                            nxt_r.c = sum[9];
                            nxt_r.hc = sum[8];
                            nxt_r.z = (res == 8'h00);
                            wr_back = 1'b1;
                        end
                        lfaso_pkg::OP_ADDC_FILE: begin
                            sum = add8(r_ff.acc, opnd, r_ff.c);
                            res = sum[7:0];
                            nxt_r.c = sum[9];
                            nxt_r.hc = sum[8];
                            nxt_r.z = (res == 8'h00);
                            wr_back = 1'b1;
                        end
                        lfaso_pkg::OP_ASR_FILE: begin
                            res = {opnd[7], opnd[7:1]};
                            nxt_r.c = opnd[0];
                            nxt_r.z = (res == 8'h00);
                            wr_back = 1'b1;
                        end
                        default: begin
                            // Not ours: retire with no effect
                        end
                    endcase
                end
                // Destination select for the file-register group
                if (wr_back) begin
                    if (r_ff.instr[lfaso_pkg::DEST_BIT]) begin
                        mif.wr_en = 1'b1;
                        mif.wr_addr = r_ff.eaddr;
                        mif.wr_data = res;
                        nxt_r.fw_valid = 1'b1;
                        nxt_r.fw_addr = r_ff.eaddr;
                        nxt_r.fw_data = res;
                    end else begin
                        nxt_r.acc = res;
                    end
                end
            end
            default: begin
                nxt_r.state = lfaso_pkg::ST_IDLE;
                nxt_r.ready = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_ff <= '{state: lfaso_pkg::ST_IDLE, instr: 14'h0000, eaddr: 7'h00,
                      acc: lfaso_pkg::ACC_RST, c: 1'b0, hc: 1'b0, z: 1'b0,
                      ptr0: lfaso_pkg::PTR_RST, ptr1: lfaso_pkg::PTR_RST,
                      ready: 1'b1, done: 1'b0, fw_valid: 1'b0, fw_addr: 7'h00,
                      fw_data: 8'h00};
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ------------------------------------------------------------
    // Memory and outputs
    // ------------------------------------------------------------
    lfaso_file_mem u_mem (
        .clk(clk),
        .port(mif.mem)
    );

    assign ready = r_ff.ready;
    assign done = r_ff.done;
    assign acc = r_ff.acc;
    assign carry_flag = r_ff.c;
    assign half_carry_flag = r_ff.hc;
    assign zero_flag = r_ff.z;
    assign indirect_pointer_pair0 = r_ff.ptr0;
    assign indirect_pointer_pair1 = r_ff.ptr1;
    assign fw_valid = r_ff.fw_valid;
    assign fw_addr = r_ff.fw_addr;
    assign fw_data = r_ff.fw_data;

endmodule

// File: lfaso_core_sva.sv
// Checker for the execution core: latency, results, flags and destination.
// Assumes it is bound to lfaso_core and sees only that module's ports.
module lfaso_core_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Instruction and handshake
    input wire logic instr_valid,
    input wire logic [13:0] instr_word,
    input wire logic ready,
    input wire logic done,
    // Architectural state
    input wire logic [7:0] acc,
    input wire logic carry_flag,
    input wire logic half_carry_flag,
    input wire logic zero_flag,
    input wire logic [15:0] indirect_pointer_pair0,
    input wire logic [15:0] indirect_pointer_pair1,
    // File write monitor
    input wire logic fw_valid,
    input wire logic [6:0] fw_addr,
    input wire logic [7:0] fw_data
);
    // ----------------------------------------------------------
    // Operands captured at take, judged when done shows
    // ----------------------------------------------------------
    logic take;
    logic [13:0] a_w;
    logic [7:0] a_acc;
    logic a_c;
    logic a_h;
    logic [15:0] a_p0;
    logic [15:0] a_p1;
    logic [4:0] hsum;
    function automatic logic fop(logic [13:0] w);
        return w[13:8] inside {lfaso_pkg::OP_AND_FILE, lfaso_pkg::OP_ADD_FILE,
            lfaso_pkg::OP_ASR_FILE, lfaso_pkg::OP_ADDC_FILE};
    endfunction
    assign take = ready && instr_valid;
    assign hsum = {1'b0, a_acc[3:0]} + {1'b0, a_w[3:0]};
    // Capture held until the next take, which can come in the same cycle as done at the earliest
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {a_w, a_acc, a_c, a_h, a_p0, a_p1} <= '0;
        end else if (take) begin
            {a_w, a_acc, a_c, a_h, a_p0, a_p1} <= {instr_word, acc, carry_flag,
                half_carry_flag, indirect_pointer_pair0, indirect_pointer_pair1};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_two; !done ##1 done; endsequence
    sequence s_three; !done[*2] ##1 done; endsequence
    AST_LIT_LAT: assert property (take && (instr_word[13:8] == lfaso_pkg::OP_AND_IMM ||
        instr_word[13:8] == lfaso_pkg::OP_ADD_IMM) |=> s_two) else $error("literal op latency");
    AST_XTRA: assert property (take && fop(instr_word) && indirect_pointer_pair0[15] &&
        instr_word[6:0] == lfaso_pkg::IND_PORT0 |=> s_three) else $error("no extra cycle");
    AST_ANDI: assert property (done && a_w[13:8] == lfaso_pkg::OP_AND_IMM |->
        acc == (a_acc & a_w[7:0]) && zero_flag == (acc == 8'h00) && carry_flag == a_c
        && half_carry_flag == a_h) else $error("and literal result");
    AST_ADDI: assert property (done && a_w[13:8] == lfaso_pkg::OP_ADD_IMM |->
        {carry_flag, acc} == {1'b0, a_acc} + {1'b0, a_w[7:0]} && half_carry_flag == hsum[4]
        && zero_flag == (acc == 8'h00)) else $error("add literal result");
    AST_PADD: assert property (done && a_w[13:7] == lfaso_pkg::OP_PTR_ADD |->
        (a_w[6] ? indirect_pointer_pair1 : indirect_pointer_pair0) == (a_w[6] ? a_p1 : a_p0)
        + {{10{a_w[5]}}, a_w[5:0]} && $stable({carry_flag, half_carry_flag, zero_flag}))
        else $error("pointer add result");
    AST_DEST1: assert property (done && fop(a_w) && a_w[7] |-> fw_valid && acc == a_acc)
        else $error("d=1 must write file only");
    AST_DEST0: assert property (done && fop(a_w) && !a_w[7] |-> !fw_valid)
        else $error("d=0 wrote the file");
    AST_FADDR: assert property (done && fop(a_w) && a_w[7] && a_w[6:1] != 6'h00 |->
        fw_addr == a_w[6:0]) else $error("file write address");
    AST_ZERO: assert property (done && fop(a_w) |->
        zero_flag == (a_w[7] ? fw_data == 8'h00 : acc == 8'h00)) else $error("zero flag");
    AST_SIGN: assert property (fw_valid && a_w[13:8] == lfaso_pkg::OP_ASR_FILE |->
        fw_data[7] == fw_data[6]) else $error("shift lost sign");
endmodule
bind lfaso_core lfaso_core_sva i_sva (.clk(clk), .sys_rst(sys_rst),
    .instr_valid(instr_valid), .instr_word(instr_word), .ready(ready), .done(done),
    .acc(acc), .carry_flag(carry_flag), .half_carry_flag(half_carry_flag),
    .zero_flag(zero_flag), .indirect_pointer_pair0(indirect_pointer_pair0),
    .indirect_pointer_pair1(indirect_pointer_pair1), .fw_valid(fw_valid),
    .fw_addr(fw_addr), .fw_data(fw_data));

// File: lfaso_tb.sv
// Testbench for the execution core: literal, pointer, file and indirect cases.
// Assumes lfaso_pkg and lfaso_core are compiled first; the checker is bound.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic sys_rst, instr_valid, ld_valid, ready, done, c_f, h_f, z_f, fw_valid;
    logic [13:0] instr_word;
    logic [6:0] ld_addr, fw_addr;
    logic [7:0] ld_data, acc, fw_data;
    logic [15:0] p0, p1;
    int err_count = 0;
    int checked = 0;
    always #2.5 clk = ~clk;
    lfaso_core i_dut (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
        .instr_word(instr_word), .ld_valid(ld_valid), .ld_addr(ld_addr), .ld_data(ld_data),
        .ready(ready), .done(done), .acc(acc), .carry_flag(c_f), .half_carry_flag(h_f),
        .zero_flag(z_f), .indirect_pointer_pair0(p0), .indirect_pointer_pair1(p1),
        .fw_valid(fw_valid), .fw_addr(fw_addr), .fw_data(fw_data));
    // ----------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------
    task automatic end_sim();
        $display("mismatches %0d of %0d checks", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    task automatic st(input logic [10:0] e);
        chk("acc_flags", {5'h00, e}, {5'h00, acc, c_f, h_f, z_f});
    endtask
    task automatic fwc(input logic [6:0] a, input logic [7:0] d);
        chk("file_write", {1'b1, a, d}, {fw_valid, fw_addr, fw_data});
    endtask
    // Drive one instruction, then count edges until done shows; bounded wait
    task automatic run(input logic [13:0] w, input int lat);
        int n;
        n = 0;
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_word <= w;
        @(posedge clk);
        instr_valid <= 1'b0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 8);
        if (done !== 1'b1) begin
            err_count++;
            end_sim();
        end else begin
            chk("latency", 16'(lat), 16'(n));
        end
    endtask
    task automatic load(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        ld_valid <= 1'b1;
        ld_addr <= a;
        ld_data <= d;
        @(posedge clk);
        ld_valid <= 1'b0;
    endtask
    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_reset();
        #1;
        chk("ready", 16'h0001, {15'h0000, ready});
        st(11'h000);
        chk("pointers", 16'h0000, p0 | p1);
    endtask
    task automatic t_lit();
        run({lfaso_pkg::OP_ADD_IMM, 8'hff}, 1);
        st({8'hff, 3'b000});
        run({lfaso_pkg::OP_ADD_IMM, 8'h01}, 1);
        st({8'h00, 3'b111});
        run({lfaso_pkg::OP_AND_IMM, 8'haa}, 1);
        st({8'h00, 3'b111});
        run({lfaso_pkg::OP_ADD_IMM, 8'h3c}, 1);
        st({8'h3c, 3'b000});
        run({lfaso_pkg::OP_AND_IMM, 8'hc3}, 1);
        st({8'h00, 3'b001});
    endtask
    // Wrap both ways; the flags left by the literal ops must survive
    task automatic t_ptr();
        run({lfaso_pkg::OP_PTR_ADD, 1'b0, 6'h3f}, 1);
        chk("ptr0", 16'hffff, p0);
        run({lfaso_pkg::OP_PTR_ADD, 1'b0, 6'h01}, 1);
        chk("ptr0", 16'h0000, p0);
        run({lfaso_pkg::OP_PTR_ADD, 1'b1, 6'h1f}, 1);
        chk("ptr1", 16'h001f, p1);
        run({lfaso_pkg::OP_PTR_ADD, 1'b0, 6'h20}, 1);
        chk("ptr0", 16'hffe0, p0);
        st({8'h00, 3'b001});
    endtask
    task automatic t_file();
        load(7'h10, 8'h81);
        load(7'h11, 8'h0f);
        load(7'h12, 8'h03);
        run({lfaso_pkg::OP_ADD_IMM, 8'hf1}, 1);
        run({lfaso_pkg::OP_ADD_FILE, 1'b0, 7'h11}, 1);
        st({8'h00, 3'b111});
        chk("fw_valid", 16'h0000, {15'h0000, fw_valid});
        run({lfaso_pkg::OP_ADDC_FILE, 1'b1, 7'h10}, 1);
        st({8'h00, 3'b000});
        fwc(7'h10, 8'h82);
        run({lfaso_pkg::OP_ASR_FILE, 1'b0, 7'h10}, 1);
        st({8'hc1, 3'b000});
        run({lfaso_pkg::OP_ASR_FILE, 1'b1, 7'h12}, 1);
        st({8'hc1, 3'b100});
        fwc(7'h12, 8'h01);
        run({lfaso_pkg::OP_AND_FILE, 1'b0, 7'h11}, 1);
        st({8'h01, 3'b100});
        run({lfaso_pkg::OP_AND_FILE, 1'b1, 7'h10}, 1);
        st({8'h01, 3'b101});
        fwc(7'h10, 8'h00);
    endtask
    // Port 1 points low (no stall), port 0 points high (one stall cycle)
    task automatic t_ind();
        load(7'h1f, 8'h05);
        load(7'h60, 8'h10);
        run({lfaso_pkg::OP_ADD_FILE, 1'b0, lfaso_pkg::IND_PORT1}, 1);
        st({8'h06, 3'b000});
        run({lfaso_pkg::OP_ADD_FILE, 1'b0, lfaso_pkg::IND_PORT0}, 2);
        st({8'h16, 3'b000});
        // An opcode outside the group retires with no effect and no stall
        run(14'h0000, 1);
        st({8'h16, 3'b000});
    endtask
    // Reset in mid-run must clear the state, then work must resume
    task automatic t_rst2();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        run({lfaso_pkg::OP_ADD_IMM, 8'h80}, 1);
        st({8'h80, 3'b000});
    endtask
    initial begin
        sys_rst = 1'b1;
        instr_valid = 1'b0;
        instr_word = 14'h0000;
        ld_valid = 1'b0;
        ld_addr = 7'h00;
        ld_data = 8'h00;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_lit();
        t_ptr();
        t_file();
        t_ind();
        t_rst2();
        end_sim();
    end
endmodule
